// >>> bss_cal_trim.sv
// Per-channel calibration offsets applied to raw measurements
module bss_cal_trim #(
  parameter int N_CAL = 12,
  parameter int IDX_W = 4,
  parameter int DW    = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Offset table access
  input  wire logic             cal_wr,
  input  wire logic [IDX_W-1:0] cal_idx,
  input  wire logic [DW-1:0]    cal_wdata,
  output logic [DW-1:0]         cal_rdata,
  // Measurement stream
  input  wire logic             meas_valid,
  input  wire logic [IDX_W-1:0] meas_chan,
  input  wire logic [DW-1:0]    meas_raw,
  output logic                  corr_valid,
  output logic [IDX_W-1:0]      corr_chan,
  output logic [DW-1:0]         corr_data
);

  logic [DW-1:0]    ofs_reg  [N_CAL];
  logic [DW-1:0]    ofs_next [N_CAL];
  logic             cv_reg;
  logic             cv_next;
  logic [IDX_W-1:0] cc_reg;
  logic [IDX_W-1:0] cc_next;
  logic [DW-1:0]    cd_reg;
  logic [DW-1:0]    cd_next;

  always_comb begin
    for (int i = 0; i < N_CAL; i++) begin
      ofs_next[i] = ofs_reg[i];
    end
    if (cal_wr && (int'(cal_idx) < N_CAL)) begin
      ofs_next[cal_idx] = cal_wdata;
    end
    cv_next = meas_valid;
    cc_next = meas_valid ? meas_chan : cc_reg;
    cd_next = cd_reg;
    // Offsets are two's complement; out-of-range channels pass untrimmed
    if (meas_valid) begin
      if (int'(meas_chan) < N_CAL) begin
        cd_next = meas_raw + ofs_reg[meas_chan];
      end else begin
        cd_next = meas_raw;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < N_CAL; i++) begin
        ofs_reg[i] <= '0;
      end
      cv_reg <= 1'b0;
      cc_reg <= '0;
      cd_reg <= '0;
    end else begin
      for (int i = 0; i < N_CAL; i++) begin
        ofs_reg[i] <= ofs_next[i];
      end
      cv_reg <= cv_next;
      cc_reg <= cc_next;
      cd_reg <= cd_next;
    end
  end

  assign cal_rdata  = (int'(cal_idx) < N_CAL) ? ofs_reg[cal_idx] : '0;
  assign corr_valid = cv_reg;
  assign corr_chan  = cc_reg;
  assign corr_data  = cd_reg;

endmodule

// >>> bss_host_model.sv
// Host model that times the alert output from each wakeup
module bss_host_model (
  // Clock and reset
  input wire logic    clk_sys,
  input wire logic    resetn,
  // Alert watch
  input wire logic    arm,
  input wire logic    alert_n,
  output logic [31:0] fall_cycle
);
  logic [31:0] cnt_reg;

  // Host trusts results only once its chosen flag pulls the alert low
  always_ff @(posedge clk_sys) begin
    if (!resetn || arm) begin
      cnt_reg <= 32'h0;
      fall_cycle <= 32'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      if (!alert_n && fall_cycle == 32'h0) fall_cycle <= cnt_reg;
    end
  end
endmodule

// >>> bss_ms_timer.sv
// Millisecond tick and elapsed-time counter since wakeup
module bss_ms_timer #(
  parameter int TICK_CYCLES = 100000,
  parameter int MS_W        = 16
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  // Control
  input  wire logic            run,
  // Time base
  output logic                 ms_tick,
  output logic [MS_W-1:0]      ms_count
);

  logic [31:0]     div_reg;
  logic [31:0]     div_next;
  logic [MS_W-1:0] ms_reg;
  logic [MS_W-1:0] ms_next;
  logic            tick_reg;
  logic            tick_next;

  always_comb begin
    div_next  = div_reg;
    ms_next   = ms_reg;
    tick_next = 1'b0;
    if (!run) begin
      div_next = 32'h0;
      ms_next  = '0;
    end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
      div_next  = 32'h0;
      tick_next = 1'b1;
      // Saturate so a long normal run never wraps back to early stages
      if (ms_reg != {MS_W{1'b1}}) begin
        ms_next = ms_reg + 1'b1;
      end
    end else begin
      div_next = div_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_reg  <= 32'h0;
      ms_reg   <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      ms_reg   <= ms_next;
      tick_reg <= tick_next;
    end
  end

  assign ms_tick  = tick_reg;
  assign ms_count = ms_reg;

endmodule

// >>> bss_pkg.sv
// Types shared by the startup sequencer modules
package bss_pkg;

  typedef enum logic [1:0] {
    st_shutdown,
    st_startup,
    st_normal
  } bss_state_type;

endpackage

// >>> bss_regs.svh
// Register map, field positions, reset values and timing for the sequencer
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH

// Register byte offsets
`define BSS_ADDR_CTRL      8'h00
`define BSS_ADDR_ALERT_SEL 8'h04
`define BSS_ADDR_STATUS    8'h08
`define BSS_ADDR_MASK      8'h0c
`define BSS_ADDR_STATE     8'h10
`define BSS_ADDR_CAL_BASE  8'h40

// Control fields
`define BSS_CTRL_FAST      0
`define BSS_CTRL_AUTO_SW   1
`define BSS_CTRL_AUX_AUTO  2
`define BSS_CTRL_HOST_SW   3
`define BSS_CTRL_SHUTDOWN  4
`define BSS_CTRL_W         4
`define BSS_CTRL_RST       4'h4

// Flag and status bit positions
`define BSS_F_INIT_BEGUN   0
`define BSS_F_INIT_DONE    1
`define BSS_F_CONV_SCAN    2
`define BSS_F_FULL_SCAN    3
`define BSS_F_AUX_ON       4
`define BSS_F_SWITCH_ON    5
`define BSS_F_W            6
`define BSS_ALERT_W        4
`define BSS_ALERT_RST      4'h0
`define BSS_MASK_RST       6'h00

// State register fields
`define BSS_ST_MS_LSB      0
`define BSS_ST_STATE_LSB   16
`define BSS_ST_FAST_BIT    18
`define BSS_ST_FLAG_LSB    24

// Timing, in milliseconds after the wakeup event
`define BSS_CLK_HZ         100000000
`define BSS_MS_PER_S       1000
`define BSS_T_AUX_MS       20
`define BSS_T_BEGIN_MS     23
`define BSS_T_DONE_SLOW_MS 47
`define BSS_T_DONE_FAST_MS 35
`define BSS_T_FULL_SLOW_MS 97
`define BSS_T_FULL_FAST_MS 62
`define BSS_T_NORMAL_MS    28
`define BSS_T_EVAL_MS      250
`define BSS_T_SWITCH_MS    278

`endif

// >>> bss_sequencer.sv
// Startup sequencer of the battery monitor: wakeup, stages, alert, trim
//
// Operation
// - Leave shutdown when thermistor two pin low or load sense pin high.
// - After wakeup, step through ordered startup stages; normal mode starts at 28 ms, before done and full scan.
// - If enabled, power auxiliary regulator one at 20 ms after wakeup.
// - Raise init begun flag at 23 ms; it may drive the alert output.
// - Raise init done and scan flags together at 47 ms, or 35 fast.
// - Raise complete scan flag at 97 ms, or 62 ms when fast.
// - Autonomous switch decision evaluated only once per 250 ms in normal.
// - Autonomous switches therefore turn on at 278 ms after wakeup.
// - Autonomous switch on only when enable is 1; else host controls.
// - Calibrate each cell, stack, pack, load, current, temperature reading.
//
// Chosen here: the placing of the registers and the plain strobed port.
`include "bss_regs.svh"

module bss_sequencer #(
  parameter int TICK_CYCLES = `BSS_CLK_HZ / `BSS_MS_PER_S,
  parameter int N_CAL       = 12,
  parameter int DW          = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Wakeup pins
  input  wire logic        thermistor_two_pin,
  input  wire logic        load_sense_pin,
  // Measurement stream
  input  wire logic        meas_valid,
  input  wire logic [3:0]  meas_chan,
  input  wire logic [DW-1:0] meas_raw,
  output logic             corr_valid,
  output logic [3:0]       corr_chan,
  output logic [DW-1:0]    corr_data,
  // Stage outputs
  output logic             aux_regulator_one,
  output logic             switch_enable,
  output logic             init_begun_flag,
  output logic             init_done_flag,
  output logic             conversion_scan_flag,
  output logic             complete_scan_flag,
  output logic             normal_mode,
  // Host signalling
  output logic             alert_n,
  output logic             irq
);

  localparam int MS_W = 16;

  //////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic cal_hit(input logic [7:0] a);
    cal_hit = (a >= `BSS_ADDR_CAL_BASE) &&
              (a < 8'(`BSS_ADDR_CAL_BASE + 4 * N_CAL)) &&
              (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] cal_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - `BSS_ADDR_CAL_BASE;
    cal_index = rel[5:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // State

  bss_pkg::bss_state_type    state_reg;
  bss_pkg::bss_state_type    state_next;
  logic [`BSS_CTRL_W-1:0]    ctrl_reg;
  logic [`BSS_CTRL_W-1:0]    ctrl_next;
  logic [`BSS_ALERT_W-1:0]   alert_sel_reg;
  logic [`BSS_ALERT_W-1:0]   alert_sel_next;
  logic [`BSS_F_W-1:0]       flag_reg;
  logic [`BSS_F_W-1:0]       flag_next;
  logic [`BSS_F_W-1:0]       status_reg;
  logic [`BSS_F_W-1:0]       status_next;
  logic [`BSS_F_W-1:0]       mask_reg;
  logic [`BSS_F_W-1:0]       mask_next;
  logic                      fast_reg;
  logic                      fast_next;
  logic [MS_W-1:0]           eval_reg;
  logic [MS_W-1:0]           eval_next;
  logic [31:0]               rdata_reg;
  logic [31:0]               rdata_next;

  logic                      ms_tick;
  logic [MS_W-1:0]           ms_count;
  logic                      wake;
  logic                      shutdown_req;
  logic [MS_W-1:0]           t_done;
  logic [MS_W-1:0]           t_full;
  logic [`BSS_F_W-1:0]       events;
  logic [DW-1:0]             cal_rdata;
  logic                      cal_wr;

  //////////////////////////////////////////////////////////////////////////
  // Time base and trim

  bss_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .MS_W        (MS_W)
  ) u_timer (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .run      (state_reg != bss_pkg::st_shutdown),
    .ms_tick  (ms_tick),
    .ms_count (ms_count)
  );

  assign cal_wr = reg_wr && cal_hit(reg_addr);

  bss_cal_trim #(
    .N_CAL (N_CAL),
    .IDX_W (4),
    .DW    (DW)
  ) u_trim (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .cal_wr     (cal_wr),
    .cal_idx    (cal_index(reg_addr)),
    .cal_wdata  (reg_wdata[DW-1:0]),
    .cal_rdata  (cal_rdata),
    .meas_valid (meas_valid),
    .meas_chan  (meas_chan),
    .meas_raw   (meas_raw),
    .corr_valid (corr_valid),
    .corr_chan  (corr_chan),
    .corr_data  (corr_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  assign wake = !thermistor_two_pin || load_sense_pin;
  assign shutdown_req = reg_wr && (reg_addr == `BSS_ADDR_CTRL) &&
                        reg_wdata[`BSS_CTRL_SHUTDOWN];

  // Speed is latched at wakeup so a mid-sequence write cannot reorder stages
  assign t_done = fast_reg ? MS_W'(`BSS_T_DONE_FAST_MS)
                           : MS_W'(`BSS_T_DONE_SLOW_MS);
  assign t_full = fast_reg ? MS_W'(`BSS_T_FULL_FAST_MS)
                           : MS_W'(`BSS_T_FULL_SLOW_MS);

  always_comb begin
    state_next = state_reg;
    flag_next  = flag_reg;
    fast_next  = fast_reg;
    eval_next  = eval_reg;
    case (state_reg)
      bss_pkg::st_shutdown: begin
        if (wake) begin
          state_next = bss_pkg::st_startup;
          fast_next  = ctrl_reg[`BSS_CTRL_FAST];
          flag_next  = '0;
        end
      end
      bss_pkg::st_startup: begin
        if (ms_count >= MS_W'(`BSS_T_NORMAL_MS)) begin
          state_next = bss_pkg::st_normal;
          eval_next  = '0;
        end
      end
      bss_pkg::st_normal: begin
        if (ms_tick) begin
          if (eval_reg == MS_W'(`BSS_T_EVAL_MS - 1)) begin
            eval_next = '0;
            // Decision only at the interval boundary, even with data ready
            if (ctrl_reg[`BSS_CTRL_AUTO_SW]) begin
              flag_next[`BSS_F_SWITCH_ON] =
                flag_reg[`BSS_F_FULL_SCAN];
            end
          end else begin
            eval_next = eval_reg + 1'b1;
          end
        end
        if (!ctrl_reg[`BSS_CTRL_AUTO_SW]) begin
          flag_next[`BSS_F_SWITCH_ON] = ctrl_reg[`BSS_CTRL_HOST_SW];
        end
      end
      default: begin
        state_next = bss_pkg::st_shutdown;
      end
    endcase
    if (state_reg != bss_pkg::st_shutdown) begin
      if (ctrl_reg[`BSS_CTRL_AUX_AUTO] &&
          ms_count >= MS_W'(`BSS_T_AUX_MS)) begin
        flag_next[`BSS_F_AUX_ON] = 1'b1;
      end
      if (ms_count >= MS_W'(`BSS_T_BEGIN_MS)) begin
        flag_next[`BSS_F_INIT_BEGUN] = 1'b1;
      end
      if (ms_count >= t_done && flag_reg[`BSS_F_INIT_BEGUN]) begin
        flag_next[`BSS_F_INIT_DONE] = 1'b1;
        flag_next[`BSS_F_CONV_SCAN] = 1'b1;
      end
      if (ms_count >= t_full && flag_reg[`BSS_F_INIT_DONE]) begin
        flag_next[`BSS_F_FULL_SCAN] = 1'b1;
      end
    end
    if (shutdown_req) begin
      state_next = bss_pkg::st_shutdown;
      flag_next  = '0;
      eval_next  = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= bss_pkg::st_shutdown;
      flag_reg  <= '0;
      fast_reg  <= 1'b0;
      eval_reg  <= '0;
    end else begin
      state_reg <= state_next;
      flag_reg  <= flag_next;
      fast_reg  <= fast_next;
      eval_reg  <= eval_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  assign events = flag_next & ~flag_reg;

  always_comb begin
    ctrl_next      = ctrl_reg;
    alert_sel_next = alert_sel_reg;
    mask_next      = mask_reg;
    status_next    = status_reg;
    rdata_next     = 32'h0;
    if (reg_wr) begin
      if (reg_addr == `BSS_ADDR_CTRL) begin
        ctrl_next = reg_wdata[`BSS_CTRL_W-1:0];
      end else if (reg_addr == `BSS_ADDR_ALERT_SEL) begin
        alert_sel_next = reg_wdata[`BSS_ALERT_W-1:0];
      end else if (reg_addr == `BSS_ADDR_STATUS) begin
        status_next = status_reg & ~reg_wdata[`BSS_F_W-1:0];
      end else if (reg_addr == `BSS_ADDR_MASK) begin
        mask_next = reg_wdata[`BSS_F_W-1:0];
      end
    end
    // A stage event in the clearing cycle survives the clear
    status_next = status_next | events;
    if (reg_rd) begin
      if (reg_addr == `BSS_ADDR_CTRL) begin
        rdata_next[`BSS_CTRL_W-1:0] = ctrl_reg;
      end else if (reg_addr == `BSS_ADDR_ALERT_SEL) begin
        rdata_next[`BSS_ALERT_W-1:0] = alert_sel_reg;
      end else if (reg_addr == `BSS_ADDR_STATUS) begin
        rdata_next[`BSS_F_W-1:0] = status_reg;
      end else if (reg_addr == `BSS_ADDR_MASK) begin
        rdata_next[`BSS_F_W-1:0] = mask_reg;
      end else if (reg_addr == `BSS_ADDR_STATE) begin
        rdata_next[`BSS_ST_MS_LSB +: MS_W] = ms_count;
        rdata_next[`BSS_ST_STATE_LSB +: 2] = state_reg;
        rdata_next[`BSS_ST_FAST_BIT]       = fast_reg;
        rdata_next[`BSS_ST_FLAG_LSB +: `BSS_F_W] = flag_reg;
      end else if (cal_hit(reg_addr)) begin
        rdata_next[DW-1:0] = cal_rdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg      <= `BSS_CTRL_RST;
      alert_sel_reg <= `BSS_ALERT_RST;
      mask_reg      <= `BSS_MASK_RST;
      status_reg    <= '0;
      rdata_reg     <= 32'h0;
    end else begin
      ctrl_reg      <= ctrl_next;
      alert_sel_reg <= alert_sel_next;
      mask_reg      <= mask_next;
      status_reg    <= status_next;
      rdata_reg     <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata            = rdata_reg;
  assign aux_regulator_one    = flag_reg[`BSS_F_AUX_ON];
  assign switch_enable        = flag_reg[`BSS_F_SWITCH_ON];
  assign init_begun_flag      = flag_reg[`BSS_F_INIT_BEGUN];
  assign init_done_flag       = flag_reg[`BSS_F_INIT_DONE];
  assign conversion_scan_flag = flag_reg[`BSS_F_CONV_SCAN];
  assign complete_scan_flag   = flag_reg[`BSS_F_FULL_SCAN];
  assign normal_mode          = (state_reg == bss_pkg::st_normal);
  // Alert shows live stage levels so a host can poll startup progress
  assign alert_n = !(|(flag_reg[`BSS_ALERT_W-1:0] & alert_sel_reg));
  assign irq     = |(status_reg & mask_reg);

endmodule

// >>> bss_sequencer_sva.sv
// Checker of stage order and stage timing at the sequencer ports
module bss_sequencer_sva #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Pins and stages
  input wire logic        thermistor_two_pin,
  input wire logic        load_sense_pin,
  input wire logic        aux_regulator_one,
  input wire logic        switch_enable,
  input wire logic        init_begun_flag,
  input wire logic        init_done_flag,
  input wire logic        conversion_scan_flag,
  input wire logic        complete_scan_flag,
  input wire logic        normal_mode
);
  logic        awake_reg;
  logic        awake_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        wake;
  logic        sd;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // Time since wakeup, zeroed at each wakeup; the awake bit is cleared by a shutdown write
  assign wake = !thermistor_two_pin || load_sense_pin;
  assign sd = reg_wr && reg_addr == 8'h00 && reg_wdata[4];

  always_comb begin
    awake_next = awake_reg;
    cnt_next = cnt_reg + 32'h1;
    if (sd) begin
      awake_next = 1'h0;
    end else if (!awake_reg && wake) begin
      awake_next = 1'h1;
      cnt_next = 32'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      awake_reg <= 1'h0;
      cnt_reg <= 32'h0;
    end else begin
      awake_reg <= awake_next;
      cnt_reg <= cnt_next;
    end
  end

  // Slack of a few cycles covers pin sampling and flag registering
  function automatic logic near(input int ms);
    return cnt_reg >= ms * TICK_CYCLES && cnt_reg <= ms * TICK_CYCLES + 4;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  wake_needed_a: assert property (!awake_reg |-> !init_begun_flag
    && !aux_regulator_one) else $error("stage reached without wakeup");
  done_order_a: assert property (init_done_flag |-> init_begun_flag)
    else $error("done flag before begun flag");
  full_order_a: assert property (
    complete_scan_flag |-> init_done_flag)
    else $error("full scan flag before done flag");
  done_scan_pair_a: assert property (
    init_done_flag == conversion_scan_flag)
    else $error("done and scan flags apart");
  switch_normal_a: assert property (switch_enable |-> normal_mode)
    else $error("switches on outside normal mode");
  flag_hold_a: assert property (
    init_begun_flag && !sd |=> init_begun_flag)
    else $error("begun flag dropped without shutdown");
  aux_time_a: assert property ($rose(aux_regulator_one) |-> near(20))
    else $error("aux regulator at wrong time");
  begun_time_a: assert property ($rose(init_begun_flag) |-> near(23))
    else $error("begun flag at wrong time");
  done_time_a: assert property ($rose(init_done_flag)
    |-> near(35) || near(47)) else $error("done flag at wrong time");
  full_time_a: assert property ($rose(complete_scan_flag)
    |-> near(62) || near(97)) else $error("full scan at wrong time");
  normal_time_a: assert property ($rose(normal_mode) |-> near(28))
    else $error("normal mode at wrong time");
endmodule

// >>> tb_bss_sequencer.sv
// Self-checking bench for the startup sequencer
module tb_bss_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] sel;
    int          done;
    int          full;
    int          aux;
    int          sw;
    bit          use_ld;
  } bss_row_type;
  bss_row_type rows [4] = '{'{32'h6, 32'h1, 47, 97, 20, 278, 1'h0},
    '{32'h7, 32'h2, 35, 62, 20, 278, 1'h1},
    '{32'h8, 32'h8, 47, 97, 0, 28, 1'h0},
    '{32'h1, 32'h4, 35, 62, 0, 0, 1'h1}};
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic        thermistor_two_pin = 1'h1;
  logic        load_sense_pin = 1'h0;
  logic        meas_valid = 1'h0;
  logic [3:0]  meas_chan = 4'h0;
  logic [15:0] meas_raw = 16'h0;
  logic        corr_valid;
  logic [3:0]  corr_chan;
  logic [15:0] corr_data;
  logic        aux_regulator_one;
  logic        switch_enable;
  logic        init_begun_flag;
  logic        init_done_flag;
  logic        conversion_scan_flag;
  logic        complete_scan_flag;
  logic        normal_mode;
  logic        alert_n;
  logic        irq;
  logic        arm = 1'h0;
  logic [31:0] fall_cycle;
  logic [31:0] d;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  bss_sequencer #(.TICK_CYCLES(T)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thermistor_two_pin(thermistor_two_pin), .load_sense_pin(load_sense_pin),
    .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_raw(meas_raw),
    .corr_valid(corr_valid), .corr_chan(corr_chan), .corr_data(corr_data),
    .aux_regulator_one(aux_regulator_one), .switch_enable(switch_enable),
    .init_begun_flag(init_begun_flag), .init_done_flag(init_done_flag),
    .conversion_scan_flag(conversion_scan_flag),
    .complete_scan_flag(complete_scan_flag), .normal_mode(normal_mode),
    .alert_n(alert_n), .irq(irq));

  bss_host_model host (.clk_sys(clk_sys), .resetn(resetn), .arm(arm),
    .alert_n(alert_n), .fall_cycle(fall_cycle));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  // Wakes on one pin, then logs the first ms of each stage output except normal_mode
  task automatic run_row(input bss_row_type r);
    int          t [6];
    logic [5:0]  f;
    int          ea;
    wr(8'h00, 32'h10);
    wr(8'h00, r.ctrl);
    wr(8'h04, r.sel);
    wr(8'h08, 32'h3f);
    t = '{default: 0};
    ea = r.sel[0] ? 23 : r.sel[3] ? r.full : r.done;
    @(posedge clk_sys);
    if (r.use_ld) load_sense_pin <= 1'h1;
    else thermistor_two_pin <= 1'h0;
    arm <= 1'h1;
    @(posedge clk_sys);
    load_sense_pin <= 1'h0;
    thermistor_two_pin <= 1'h1;
    arm <= 1'h0;
    for (int c = 1; c < 290 * T; c++) begin
      @(posedge clk_sys);
      #1;
      f = {switch_enable, aux_regulator_one, complete_scan_flag,
           conversion_scan_flag, init_done_flag, init_begun_flag};
      for (int i = 0; i < 6; i++) if (f[i] === 1'h1 && t[i] == 0) t[i] = c / T;
    end
    chk("begun_ms", t[0], 23);
    chk("done_ms", t[1], r.done);
    chk("scan_ms", t[2], r.done);
    chk("full_ms", t[3], r.full);
    chk("aux_ms", t[4], r.aux);
    chk("switch_ms", t[5], r.sw);
    chk("alert_ms", fall_cycle / T, ea);
    chk("irq", irq, 1'h1);
    rd(8'h08, d);
    chk("status", d, {26'h0, r.sw != 0, r.aux != 0, 4'hf});
    rd(8'h10, d);
    chk("state", d[18:16], {r.ctrl[0], 2'h2});
  endtask

  task automatic trim(input logic [3:0] ch, input logic [15:0] raw,
                      input logic [15:0] exp);
    @(posedge clk_sys);
    meas_valid <= 1'h1;
    meas_chan <= ch;
    meas_raw <= raw;
    @(posedge clk_sys);
    meas_valid <= 1'h0;
    #1;
    chk("corr_valid", corr_valid, 1'h1);
    chk("corr_chan", corr_chan, ch);
    chk("corr_data", corr_data, exp);
  endtask

  task automatic final_report;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    @(posedge clk_sys);
    #1;
    chk("alert_rst", alert_n, 1'h1);
    chk("irq_rst", irq, 1'h0);
    chk("normal_rst", normal_mode, 1'h0);
    chk("begun_rst", init_begun_flag, 1'h0);
    chk("switch_rst", switch_enable, 1'h0);
    rd(8'h00, d);
    chk("ctrl_rst", d, 32'h4);
    @(posedge clk_sys);
    #1;
    chk("rdata_idle", reg_rdata, 32'h0);
    wr(8'h0c, 32'h3f);
    foreach (rows[i]) run_row(rows[i]);
    wr(8'h08, 32'h3f);
    rd(8'h08, d);
    chk("status_clr", d, 32'h0);
    chk("irq_clr", irq, 1'h0);
    // Shutdown in mid-startup, with only the done event unmasked
    wr(8'h0c, 32'h2);
    wr(8'h00, 32'h10);
    wr(8'h00, 32'h6);
    @(posedge clk_sys);
    thermistor_two_pin <= 1'h0;
    @(posedge clk_sys);
    thermistor_two_pin <= 1'h1;
    repeat (25 * T) @(posedge clk_sys);
    #1;
    chk("begun_mid", init_begun_flag, 1'h1);
    chk("irq_masked", irq, 1'h0);
    // Speed is taken at wakeup only; a later write must not change it
    wr(8'h00, 32'h7);
    rd(8'h10, d);
    chk("fast_latched", d[18], 1'h0);
    wr(8'h00, 32'h10);
    @(posedge clk_sys);
    #1;
    chk("begun_abort", init_begun_flag, 1'h0);
    repeat (30 * T) @(posedge clk_sys);
    #1;
    chk("no_wake", init_done_flag, 1'h0);
    wr(8'h48, 32'h5);
    rd(8'h48, d);
    chk("cal_rb", d, 32'h5);
    rd(8'h70, d);
    chk("unmapped", d, 32'h0);
    trim(4'h2, 16'hfffe, 16'h0003);
    trim(4'hd, 16'h1234, 16'h1234);
    final_report;
  end

  initial begin
    #500000;
    n_fail++;
    final_report;
  end
endmodule

bind bss_sequencer bss_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) sva_i (
  .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .thermistor_two_pin(thermistor_two_pin), .load_sense_pin(load_sense_pin),
  .aux_regulator_one(aux_regulator_one), .switch_enable(switch_enable),
  .init_begun_flag(init_begun_flag), .init_done_flag(init_done_flag),
  .conversion_scan_flag(conversion_scan_flag),
  .complete_scan_flag(complete_scan_flag), .normal_mode(normal_mode));
